// [design/spcs_host.v]
`timescale 1ns/1ps
`include "spcs_defs.vh"
module spcs_host #(
  parameter AW = 26,
  parameter [15:0] LOCK_VALID_MASK = 16'h0006,
  parameter [15:0] LOCK_MODE_MASK = 16'h0006
) (
  input wire SYS_CLK_I,
  input wire NRST_I,
  input wire CMD_VALID_I,
  input wire [3:0] CMD_OP_I,
  input wire [AW-1:0] CMD_ADDR_I,
  input wire [15:0] CMD_DATA_I,
  input wire [63:0] CMD_PASSWORD_I,
  output reg CMD_READY_O,
  output reg DONE_O,
  output reg ERROR_O,
  output reg [63:0] RESULT_O,
  input wire [15:0] DQ_I,
  output wire [15:0] DQ_O,
  output wire DQ_OE_O,
  output wire [AW-1:0] ADDR_O,
  output wire CE_N_O,
  output wire WE_N_O,
  output wire OE_N_O
);
  localparam S_IDLE = 3'b001;
  localparam S_RUN = 3'b010;
  localparam S_WAIT = 3'b100;
  localparam [4:0] MAXC = 5'd14;
  reg [15:0] dq_meta_reg;
  reg [15:0] dq_sync_reg;
  reg [2:0] st_reg;
  reg [3:0] op_reg;
  reg [AW-1:0] addr_reg;
  reg [15:0] data_reg;
  reg [63:0] pw_reg;
  reg [4:0] idx_reg;
  reg [4:0] len_reg;
  reg go_reg;
  wire done;
  wire [15:0] rdata;
  reg c_wr;
  reg [AW-1:0] c_addr;
  reg [15:0] c_data;
  reg [7:0] ent;
  wire [AW-1:0] sect;
  assign sect = {addr_reg[AW-1:`SPCS_SECT_LSB],
                 {`SPCS_SECT_LSB{1'b0}}};
  always @(posedge SYS_CLK_I) begin
    dq_meta_reg <= DQ_I;
    dq_sync_reg <= dq_meta_reg;
  end
  always @* begin
    case (op_reg)
      `SPCS_OP_LOCK_PROG, `SPCS_OP_LOCK_READ: ent = `SPCS_ENT_LOCKREG;
      `SPCS_OP_PW_PROG, `SPCS_OP_PW_READ,
      `SPCS_OP_PW_UNLOCK: ent = `SPCS_ENT_PASSWD;
      `SPCS_OP_PERS_PROG, `SPCS_OP_PERS_ERASE,
      `SPCS_OP_PERS_READ: ent = `SPCS_ENT_PERSIST;
      `SPCS_OP_FRZ_CLEAR, `SPCS_OP_FRZ_READ: ent = `SPCS_ENT_FREEZE;
      `SPCS_OP_ID_READ: ent = `SPCS_D_EXIT1;
      default: ent = `SPCS_ENT_VOLATILE;
    endcase
  end
  // Cycle sequence: 3 entry cycles, body, then exit
  always @* begin
    c_wr = 1'b1;
    c_addr = {AW{1'b0}};
    c_data = 16'h0000;
    case (idx_reg)
      5'd0: begin
        c_addr = {{(AW-12){1'b0}}, `SPCS_UNLOCK_A1};
        c_data = {8'h00, `SPCS_UNLOCK_D1};
      end
      5'd1: begin
        c_addr = {{(AW-12){1'b0}}, `SPCS_UNLOCK_A2};
        c_data = {8'h00, `SPCS_UNLOCK_D2};
      end
      5'd2: begin
        c_addr = {{(AW-12){1'b0}}, `SPCS_UNLOCK_A1} |
                 (op_reg == `SPCS_OP_ID_READ ? sect : {AW{1'b0}});
        c_data = {8'h00, ent};
      end
      default: begin
        if (idx_reg == len_reg - 5'd1) begin
          c_data = {8'h00, `SPCS_D_RESET};
        end else begin
          case (op_reg)
            `SPCS_OP_LOCK_PROG: begin
              if (idx_reg == 5'd3) c_data = {8'h00, `SPCS_D_PROG};
              else c_data = data_reg;
            end
            `SPCS_OP_PW_PROG: begin
              if (idx_reg == 5'd3) c_data = {8'h00, `SPCS_D_PROG};
              else begin
                c_addr = {{(AW-2){1'b0}}, addr_reg[1:0]};
                c_data = data_reg;
              end
            end
            `SPCS_OP_PW_READ: begin
              c_wr = 1'b0;
              c_addr = {{(AW-5){1'b0}}, idx_reg - 5'd3};
            end
            `SPCS_OP_PW_UNLOCK: begin
              case (idx_reg)
                5'd3: c_data = {8'h00, `SPCS_D_UNLK1};
                5'd4: c_data = {8'h00, `SPCS_D_UNLK2};
                5'd9: c_data = {8'h00, `SPCS_D_UNLK_CONF};
                default: begin
                  c_addr = {{(AW-2){1'b0}}, idx_reg[1:0] - 2'b01};
                  c_data = pw_reg[16*(idx_reg-5'd5) +: 16];
                end
              endcase
            end
            `SPCS_OP_PERS_PROG, `SPCS_OP_FRZ_CLEAR,
            `SPCS_OP_VOL_SET: begin
              if (idx_reg == 5'd3) c_data = {8'h00, `SPCS_D_PROG};
              else begin
                if (op_reg != `SPCS_OP_FRZ_CLEAR) c_addr = sect;
                c_data = {8'h00, `SPCS_D_ZERO};
              end
            end
            `SPCS_OP_VOL_CLEAR: begin
              if (idx_reg == 5'd3) c_data = {8'h00, `SPCS_D_PROG};
              else begin
                c_addr = sect;
                c_data = {8'h00, `SPCS_D_ONE};
              end
            end
            `SPCS_OP_PERS_ERASE: begin
              if (idx_reg == 5'd3) c_data = {8'h00, `SPCS_D_ERASE};
              else c_data = {8'h00, `SPCS_D_ERASE_CONF};
            end
            `SPCS_OP_ID_READ: begin
              c_wr = 1'b0;
              c_addr = sect | {{(AW-16){1'b0}}, `SPCS_ID_PROT_OFS};
            end
            `SPCS_OP_PERS_READ, `SPCS_OP_VOL_READ: begin
              c_wr = 1'b0;
              c_addr = sect;
            end
            default: c_wr = 1'b0;
          endcase
        end
      end
    endcase
  end
  function [4:0] op_len;
    input [3:0] op;
    begin
      case (op)
        `SPCS_OP_LOCK_READ, `SPCS_OP_PERS_READ, `SPCS_OP_FRZ_READ,
        `SPCS_OP_VOL_READ, `SPCS_OP_ID_READ: op_len = 5'd5;
        `SPCS_OP_PW_READ: op_len = 5'd8;
        `SPCS_OP_PW_UNLOCK: op_len = 5'd11;
        default: op_len = 5'd6;
      endcase
    end
  endfunction
  always @(posedge SYS_CLK_I) begin
    go_reg <= 1'b0;
    DONE_O <= 1'b0;
    if (!NRST_I) begin
      st_reg <= S_IDLE;
      op_reg <= 4'h0;
      addr_reg <= {AW{1'b0}};
      data_reg <= 16'h0000;
      pw_reg <= 64'h0;
      idx_reg <= 5'd0;
      len_reg <= 5'd0;
      CMD_READY_O <= 1'b0;
      ERROR_O <= 1'b0;
      RESULT_O <= 64'h0;
    end else begin
      case (st_reg)
        S_IDLE: begin
          CMD_READY_O <= 1'b1;
          if (CMD_VALID_I && CMD_READY_O) begin
            CMD_READY_O <= 1'b0;
            op_reg <= CMD_OP_I;
            addr_reg <= CMD_ADDR_I;
            data_reg <= CMD_DATA_I;
            pw_reg <= CMD_PASSWORD_I;
            RESULT_O <= 64'h0;
            idx_reg <= 5'd0;
            len_reg <= op_len(CMD_OP_I);
            if (CMD_OP_I > `SPCS_OP_ID_READ ||
                (CMD_OP_I == `SPCS_OP_LOCK_PROG &&
                 (~CMD_DATA_I & LOCK_MODE_MASK) == LOCK_MODE_MASK)) begin
              ERROR_O <= 1'b1;
              DONE_O <= 1'b1;
            end else begin
              ERROR_O <= 1'b0;
              go_reg <= 1'b1;
              st_reg <= S_RUN;
            end
          end
        end
        S_RUN: st_reg <= S_WAIT;
        S_WAIT: begin
          if (done) begin
            if (!c_wr) begin
              if (op_reg == `SPCS_OP_PW_READ)
                RESULT_O[16*(idx_reg-5'd3) +: 16] <= rdata;
              else if (op_reg == `SPCS_OP_LOCK_READ)
                RESULT_O[15:0] <= rdata & LOCK_VALID_MASK;
              else
                RESULT_O[15:0] <= {15'h0, rdata[0]};
            end
            if (idx_reg == len_reg - 5'd1 || idx_reg == MAXC) begin
              DONE_O <= 1'b1;
              st_reg <= S_IDLE;
            end else begin
              idx_reg <= idx_reg + 5'd1;
              go_reg <= 1'b1;
              st_reg <= S_RUN;
            end
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end
  spcs_bus_cycle #(.AW(AW)) u_cycle (
    .clk_i(SYS_CLK_I),
    .nrst_i(NRST_I),
    .go_i(go_reg),
    .wr_i(c_wr),
    .addr_i(c_addr),
    .data_i(c_data),
    .dq_sync_i(dq_sync_reg),
    .done_o(done),
    .rdata_o(rdata),
    .addr_o(ADDR_O),
    .dq_o(DQ_O),
    .dq_oe_o(DQ_OE_O),
    .ce_n_o(CE_N_O),
    .we_n_o(WE_N_O),
    .oe_n_o(OE_N_O)
  );
endmodule

// [design/spcs_defs.vh]
`ifndef SPCS_DEFS_VH
`define SPCS_DEFS_VH
// Unlock cycles
`define SPCS_UNLOCK_A1 12'h555
`define SPCS_UNLOCK_D1 8'haa
`define SPCS_UNLOCK_A2 12'h2aa
`define SPCS_UNLOCK_D2 8'h55
// Space entry codes
`define SPCS_ENT_LOCKREG 8'h40
`define SPCS_ENT_PASSWD 8'h60
`define SPCS_ENT_PERSIST 8'hc0
`define SPCS_ENT_FREEZE 8'h50
`define SPCS_ENT_VOLATILE 8'he0
// Command data
`define SPCS_D_PROG 8'ha0
`define SPCS_D_ERASE 8'h80
`define SPCS_D_ERASE_CONF 8'h30
`define SPCS_D_EXIT1 8'h90
`define SPCS_D_ZERO 8'h00
`define SPCS_D_ONE 8'h01
`define SPCS_D_RESET 8'hf0
`define SPCS_D_UNLK1 8'h25
`define SPCS_D_UNLK2 8'h03
`define SPCS_D_UNLK_CONF 8'h29
// Operation codes on the user port
`define SPCS_OP_LOCK_PROG 4'h0
`define SPCS_OP_LOCK_READ 4'h1
`define SPCS_OP_PW_PROG 4'h2
`define SPCS_OP_PW_READ 4'h3
`define SPCS_OP_PW_UNLOCK 4'h4
`define SPCS_OP_PERS_PROG 4'h5
`define SPCS_OP_PERS_ERASE 4'h6
`define SPCS_OP_PERS_READ 4'h7
`define SPCS_OP_FRZ_CLEAR 4'h8
`define SPCS_OP_FRZ_READ 4'h9
`define SPCS_OP_VOL_SET 4'ha
`define SPCS_OP_VOL_CLEAR 4'hb
`define SPCS_OP_VOL_READ 4'hc
`define SPCS_OP_ID_READ 4'hd
// Bus timing in ns, strobe length rounded up to cycles of the system clock
`define SPCS_T_STROBE_NS 100
`define SPCS_CLK_NS 50
`define SPCS_STROBE_CYC ((`SPCS_T_STROBE_NS + `SPCS_CLK_NS - 1) / `SPCS_CLK_NS)
`define SPCS_ID_PROT_OFS 16'h0002
`define SPCS_SECT_LSB 16
`endif

// [design/spcs_bus_cycle.v]
`timescale 1ns/1ps
`include "spcs_defs.vh"
// Runs one asynchronous write or read cycle on the flash pins.
module spcs_bus_cycle #(
  parameter AW = 26,
  parameter STROBE = `SPCS_STROBE_CYC
) (
  input wire clk_i,
  input wire nrst_i,
  input wire go_i,
  input wire wr_i,
  input wire [AW-1:0] addr_i,
  input wire [15:0] data_i,
  input wire [15:0] dq_sync_i,
  output reg done_o,
  output reg [15:0] rdata_o,
  output reg [AW-1:0] addr_o,
  output reg [15:0] dq_o,
  output reg dq_oe_o,
  output reg ce_n_o,
  output reg we_n_o,
  output reg oe_n_o
);
  localparam S_IDLE = 3'b001;
  localparam S_STRB = 3'b010;
  localparam S_HOLD = 3'b100;
  reg [2:0] st_reg;
  reg [7:0] cnt_reg;
  reg wr_reg;
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (!nrst_i) begin
      st_reg <= S_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      rdata_o <= 16'h0000;
      addr_o <= {AW{1'b0}};
      dq_o <= 16'h0000;
      dq_oe_o <= 1'b0;
      ce_n_o <= 1'b1;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
    end else begin
      case (st_reg)
        S_IDLE: begin
          if (go_i) begin
            wr_reg <= wr_i;
            addr_o <= addr_i;
            dq_o <= data_i;
            dq_oe_o <= wr_i;
            ce_n_o <= 1'b0;
            we_n_o <= ~wr_i;
            oe_n_o <= wr_i;
            cnt_reg <= 8'h00;
            st_reg <= S_STRB;
          end
        end
        S_STRB: begin
          // Read data passes two synchroniser stages, so wait 2 extra
          if (cnt_reg == STROBE[7:0] + 8'h02) begin
            if (!wr_reg)
              rdata_o <= dq_sync_i;
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            ce_n_o <= 1'b1;
            cnt_reg <= 8'h00;
            st_reg <= S_HOLD;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        S_HOLD: begin
          dq_oe_o <= 1'b0;
          done_o <= 1'b1;
          st_reg <= S_IDLE;
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// [dv/spcs_chk.sv]
`timescale 1ns/1ps
`include "spcs_defs.vh"
module spcs_chk #(parameter AW = 26) (
  input wire SYS_CLK_I,
  input wire NRST_I,
  input wire CMD_VALID_I,
  input wire [3:0] CMD_OP_I,
  input wire [15:0] CMD_DATA_I,
  input wire CMD_READY_O,
  input wire DONE_O,
  input wire ERROR_O,
  input wire [15:0] DQ_O,
  input wire DQ_OE_O,
  input wire [AW-1:0] ADDR_O,
  input wire CE_N_O,
  input wire WE_N_O,
  input wire OE_N_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  reg [7:0] last_reg;
  // Low byte of the latest write strobe
  always @(posedge SYS_CLK_I) begin
    if (!NRST_I) last_reg <= 8'h00;
    else if (!WE_N_O) last_reg <= DQ_O[7:0];
  end
  sequence strobe_s;
    !CE_N_O [*5] ##1 CE_N_O;
  endsequence
  sequence refuse_s;
    CE_N_O throughout (##[1:2] (DONE_O && ERROR_O));
  endsequence
  strobe_len_a: assert property ($fell(CE_N_O) |-> strobe_s)
    else $error("bad strobe length");
  write_drive_a: assert property (!WE_N_O |-> DQ_OE_O && OE_N_O && !CE_N_O)
    else $error("write without drive");
  read_float_a: assert property (!OE_N_O |-> !DQ_OE_O && WE_N_O)
    else $error("read while driving");
  unlock_bits_a: assert property (!WE_N_O && ADDR_O[10:0] == 11'h555 &&
    DQ_O[7:0] != 8'h90 |-> DQ_O[15:8] == 8'h00 && ADDR_O[AW-1:11] == 0)
    else $error("upper bits not zero");
  unlock_order_a: assert property ($fell(WE_N_O) && last_reg == 8'haa |->
    DQ_O[7:0] == `SPCS_UNLOCK_D2 && ADDR_O[10:0] == 11'h2aa)
    else $error("bad second unlock");
  pw_unlock_a: assert property ($fell(WE_N_O) && last_reg == 8'h25 |->
    DQ_O[7:0] == `SPCS_D_UNLK2 && ADDR_O == 0)
    else $error("bad unlock step");
  exit_cmd_a: assert property (DONE_O && !ERROR_O |-> last_reg == 8'hf0)
    else $error("no exit write");
  refuse_op_a: assert property (CMD_VALID_I && CMD_READY_O &&
    (CMD_OP_I > 4'hd || CMD_OP_I == `SPCS_OP_LOCK_PROG &&
    CMD_DATA_I[2:1] == 2'b00) |-> refuse_s)
    else $error("refusal wrong");
endmodule
bind spcs_host spcs_chk #(.AW(AW)) spcs_chk_i (.*);

// [dv/spcs_dev_model.sv]
`timescale 1ns/1ps
module spcs_dev_model (
  input wire [25:0] addr_i,
  input wire [15:0] dq_i,
  input wire ce_n_i,
  input wire we_n_i,
  input wire oe_n_i,
  output wire [15:0] dq_o
);
  reg [7:0] sp_reg = 8'h00;
  reg [7:0] sb_reg = 8'h00;
  reg [1:0] ct_reg = 2'h0;
  reg [15:0] lk_reg = 16'hffff;
  reg [15:0] pw_reg [0:3];
  reg [1023:0] pp_reg = {1024{1'b1}};
  reg [1023:0] vl_reg = {1024{1'b1}};
  reg fz_reg = 1'b1;
  reg [9:0] id_reg = 10'h0;
  reg [15:0] ls_reg = 16'h0;
  reg [15:0] rd;
  wire [9:0] sec = addr_i[25:16];
  wire [10:0] a = addr_i[10:0];
  wire [7:0] d = dq_i[7:0];
  reg [2:0] uk_reg = 3'h0;
  reg uk_ok = 1'b0;
  wire [1:0] uw = uk_reg[1:0] - 2'h2;
  // Flags a complete password unlock with every word at its own address
  always @(posedge we_n_i) begin
    uk_reg <= 3'h0;
    if (sp_reg == 8'h60) begin
      if (uk_reg == 3'h0 && d == 8'h25 && addr_i == 26'h0) uk_reg <= 3'h1;
      if (uk_reg == 3'h1 && d == 8'h03 && addr_i == 26'h0) uk_reg <= 3'h2;
      if (uk_reg >= 3'h2 && uk_reg <= 3'h5 && addr_i == {24'h0, uw} &&
          dq_i == pw_reg[uw]) uk_reg <= uk_reg + 3'h1;
      if (uk_reg == 3'h6 && d == 8'h29 && addr_i == 26'h0) uk_ok <= 1'b1;
    end
  end
  always @(posedge we_n_i) begin
    if (d == 8'hf0) begin
      sp_reg <= 8'h00;
      sb_reg <= 8'h00;
    end else if (sp_reg == 8'h00) begin
      ct_reg <= 2'h0;
      if (ct_reg == 2'h0 && d == 8'haa && a == 11'h555) ct_reg <= 2'h1;
      if (ct_reg == 2'h1 && d == 8'h55 && a == 11'h2aa) ct_reg <= 2'h2;
      if (ct_reg == 2'h2 && a == 11'h555) begin
        sp_reg <= d;
        id_reg <= sec;
      end
    end else if (sb_reg == 8'ha0) begin
      sb_reg <= 8'h00;
      case (sp_reg)
        8'h40: if (dq_i[2:1] == 2'h0) sp_reg <= 8'h00;
          else lk_reg <= lk_reg & dq_i;
        8'h60: pw_reg[a[1:0]] <= dq_i;
        8'hc0: pp_reg[sec] <= 1'b0;
        8'h50: fz_reg <= 1'b0;
        8'he0: vl_reg[sec] <= dq_i[0];
        default: ;
      endcase
    end else if (sb_reg == 8'h80 && d == 8'h30) begin
      pp_reg <= {1024{1'b1}};
      sb_reg <= 8'h00;
    end else sb_reg <= d;
  end
  always @* begin
    case (sp_reg)
      8'h40: rd = (lk_reg & 16'h0006) | (~ls_reg & 16'hfff9);
      8'h60: rd = pw_reg[a[1:0]];
      8'hc0: rd = {15'h0, pp_reg[sec]};
      8'h50: rd = {15'h0, fz_reg};
      8'he0: rd = {15'h0, vl_reg[sec]};
      8'h90: rd = (a[7:0] == 8'h02 && sec == id_reg) ?
        {15'h0, ~(pp_reg[id_reg] & vl_reg[id_reg])} : ~ls_reg;
      default: rd = ~ls_reg;
    endcase
  end
  always @(posedge oe_n_i) ls_reg <= rd;
  // Released bus shows the inverse of the last value
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~ls_reg;
endmodule

// [dv/sector_protection_command_sets_tb.sv]
`timescale 1ns/1ps
`include "spcs_defs.vh"
module sector_protection_command_sets_tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg valid = 1'b0;
  reg [3:0] op = 4'h0;
  reg [25:0] addr = 26'h0;
  reg [15:0] data = 16'h0;
  reg [63:0] pw = 64'h0;
  wire rdy, done, err, dq_oe, ce_n, we_n, oe_n;
  wire [63:0] res;
  wire [15:0] dqo, dqm;
  wire [25:0] ao;
  wire [15:0] dq = dq_oe ? dqo : dqm;
  integer errors = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] seed = 32'd72003;
  reg [128:0] q[$];
  reg [128:0] e;
  reg [15:0] w [0:3];
  reg [9:0] s;
  always #25 clk = ~clk;
  spcs_host spcs_host_i (.SYS_CLK_I(clk), .NRST_I(nrst), .CMD_VALID_I(valid),
    .CMD_OP_I(op), .CMD_ADDR_I(addr), .CMD_DATA_I(data), .CMD_PASSWORD_I(pw),
    .CMD_READY_O(rdy), .DONE_O(done), .ERROR_O(err), .RESULT_O(res),
    .DQ_I(dq), .DQ_O(dqo), .DQ_OE_O(dq_oe), .ADDR_O(ao), .CE_N_O(ce_n),
    .WE_N_O(we_n), .OE_N_O(oe_n));
  spcs_dev_model spcs_dev_model_i (.addr_i(ao), .dq_i(dq), .ce_n_i(ce_n),
    .we_n_i(we_n), .oe_n_i(oe_n), .dq_o(dqm));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task final_report;
    begin
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task go(input [3:0] o, input [25:0] a, input [15:0] d, input x,
    input [63:0] m, input [63:0] r);
    begin
      q.push_back({x, m, r});
      @(posedge clk);
      valid <= 1'b1;
      op <= o;
      addr <= a;
      data <= d;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      valid <= 1'b0;
    end
  endtask
  task wr(input [3:0] o, input [25:0] a, input [15:0] d, input x);
    go(o, a, d, x, 64'h0, 64'h0);
  endtask
  task rd(input [3:0] o, input [25:0] a, input [63:0] r, input [63:0] m);
    go(o, a, 16'h0, 1'b0, m, r);
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      $display("Error at %0t exp %h got %h", $time, 32'd0, cyc);
      final_report;
    end else if (done === 1'b1) begin
      e = q.pop_front();
      samples_checked = samples_checked + 1;
      if (err !== e[128] || ((res ^ e[63:0]) & e[127:64]) !== 64'h0) begin
        errors = errors + 1;
        $display("Error at %0t exp %h got %h", $time, e[63:0], res);
      end
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`SPCS_OP_LOCK_READ, 26'h0, 64'h6, 64'hffff);
    wr(`SPCS_OP_LOCK_PROG, 26'h0, 16'hfff9, 1'b1);
    wr(`SPCS_OP_LOCK_PROG, 26'h0, 16'hfffd, 1'b0);
    wr(`SPCS_OP_LOCK_PROG, 26'h0, 16'hffff, 1'b0);
    rd(`SPCS_OP_LOCK_READ, 26'h0, 64'h4, 64'hffff);
    wr(4'he, 26'h0, 16'h0, 1'b1);
    $display("done: lock");
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      w[i] = {seed[15:8], 2'b01, seed[5:0]};
      wr(`SPCS_OP_PW_PROG, i[25:0], w[i], 1'b0);
    end
    rd(`SPCS_OP_PW_READ, 26'h0, {w[3], w[2], w[1], w[0]}, {64{1'b1}});
    pw <= {w[3], w[2], w[1], w[0]};
    wr(`SPCS_OP_PW_UNLOCK, 26'h0, 16'h0, 1'b0);
    while (done !== 1'b1) @(posedge clk);
    samples_checked = samples_checked + 1;
    if (spcs_dev_model_i.uk_ok !== 1'b1) begin
      errors = errors + 1;
      $display("Error at %0t exp %h got %h", $time, 1'b1,
        spcs_dev_model_i.uk_ok);
    end
    $display("done: password");
    seed = xs(seed);
    s = seed[25:16];
    rd(`SPCS_OP_PERS_READ, {s, 16'h0}, 64'h1, 64'h1);
    wr(`SPCS_OP_PERS_PROG, {s, seed[15:0]}, 16'h0, 1'b0);
    rd(`SPCS_OP_PERS_READ, {s, ~seed[15:0]}, 64'h0, 64'h1);
    rd(`SPCS_OP_PERS_READ, {s + 10'h1, 16'h0}, 64'h1, 64'h1);
    wr(`SPCS_OP_PERS_ERASE, 26'h0, 16'h0, 1'b0);
    rd(`SPCS_OP_PERS_READ, {s, 16'h0}, 64'h1, 64'h1);
    rd(`SPCS_OP_FRZ_READ, 26'h0, 64'h1, 64'h1);
    wr(`SPCS_OP_FRZ_CLEAR, 26'h0, 16'h0, 1'b0);
    rd(`SPCS_OP_FRZ_READ, 26'h0, 64'h0, 64'h1);
    $display("done: persistent");
    for (i = 0; i < 3; i = i + 1) begin
      seed = xs(seed);
      s = seed[25:16];
      wr(`SPCS_OP_VOL_SET, {s, seed[15:0]}, 16'h0, 1'b0);
      rd(`SPCS_OP_VOL_READ, {s, 16'h0}, 64'h0, 64'h1);
      rd(`SPCS_OP_ID_READ, {s, 16'h0}, 64'h1, 64'h1);
      wr(`SPCS_OP_VOL_CLEAR, {s, ~seed[15:0]}, 16'h0, 1'b0);
      rd(`SPCS_OP_VOL_READ, {s, seed[15:0]}, 64'h1, 64'h1);
      rd(`SPCS_OP_ID_READ, {s, 16'h0}, 64'h0, 64'h1);
    end
    $display("done: volatile");
    repeat (300) @(posedge clk);
    if (q.size() != 0) begin
      errors = errors + 1;
      $display("Error at %0t exp %h got %h", $time, 32'd0, q.size());
    end
    final_report;
  end
endmodule
